// ===== src/lpf_ctrl.v
// LED modulation, fault status and reset controller with APB registers
`timescale 1ns/1ns
`include "lpf_defs.vh"

module lpf_ctrl #(
  parameter NCH = 16
) (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Two-wire link, open drain data
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n,
  // Analog fault comparators, asynchronous
  input wire [NCH-1:0] open_load_i,
  input wire [NCH-1:0] ot_chan_i,
  input wire ot_global_i,
  // Channel sink enables
  output reg [NCH-1:0] led_on
);

  // ==========================================================
  // Registers and state
  localparam integer QCYC_I = `LPF_QUANTUM_CYC - 1;
  localparam [3:0] QCYC = QCYC_I[3:0];
  localparam [2:0] PH_ADDR = 3'd0;
  localparam [2:0] PH_B1 = 3'd1;
  localparam [2:0] PH_B2 = 3'd2;
  localparam [2:0] PH_DONE = 3'd3;
  localparam [2:0] PH_IDLE = 3'd4;

  reg [7:0] mode1_r;
  reg [7:0] second_mode_register_r;
  reg [7:0] duty_r [0:NCH-1];
  reg [7:0] gduty_r;
  reg [7:0] gfreq_r;
  reg [NCH-1:0] chen_r;
  reg [NCH-1:0] ol_r;
  reg [NCH-1:0] ot_r;
  reg [3:0] q_r;
  reg [8:0] ind_r;
  reg [7:0] grp_r;
  reg [10:0] pre_r;
  reg blink_r;
  reg [1:0] scl_s_r;
  reg [1:0] sda_s_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [NCH-1:0] ol_m_r;
  reg [NCH-1:0] ol_s_r;
  reg [NCH-1:0] otc_m_r;
  reg [NCH-1:0] otc_s_r;
  reg [1:0] otg_s_r;
  reg [2:0] ph_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg ackph_r;
  reg srst_r;

  wire qtick = (q_r == QCYC);
  wire gtick = qtick && (ind_r == 9'h1FF);
  wire [10:0] pre_end = {gfreq_r, 3'b111};
  wire bstep = gtick && (pre_r == pre_end);
  wire gstep = blink_r ? bstep : gtick;
  wire grp_on = (grp_r < gduty_r);
  wire osc_off = mode1_r[`LPF_OSC_OFF_BIT];
  wire ot_clr = second_mode_register_r[`LPF_OT_CLR_BIT];
  wire otg = otg_s_r[1];
  wire [NCH-1:0] err_ok = chen_r & ~ol_r & ~ot_r;
  wire apb_acc = psel && penable && pready;
  wire [5:0] idx = paddr[7:2];
  wire idx_ok = (idx <= `LPF_IDX_CHEN) || (idx == `LPF_IDX_EFLO) ||
    (idx == `LPF_IDX_EFHI);
  wire scl_rise = scl_s_r[1] && !scl_d_r;
  wire scl_fall = !scl_s_r[1] && scl_d_r;
  wire start_c = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
  wire stop_c = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
  // Expected byte for the current phase of the soft reset call
  wire [7:0] want = (ph_r == PH_ADDR) ? `LPF_SR_ADDR :
    (ph_r == PH_B1) ? `LPF_SR_BYTE1 : `LPF_SR_BYTE2;

  // ==========================================================
  // Input synchronisers: two flops before any logic reads them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      ol_m_r <= {NCH{1'b0}};
      ol_s_r <= {NCH{1'b0}};
      otc_m_r <= {NCH{1'b0}};
      otc_s_r <= {NCH{1'b0}};
      otg_s_r <= 2'b00;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      ol_m_r <= open_load_i;
      ol_s_r <= ol_m_r;
      otc_m_r <= ot_chan_i;
      otc_s_r <= otc_m_r;
      otg_s_r <= {otg_s_r[0], ot_global_i};
    end
  end

  // ==========================================================
  // APB slave: one wait state, then pready for one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `LPF_RST_WORD;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !idx_ok;
      prdata <= `LPF_RST_WORD;
      if (psel && penable && !pready && !pwrite) begin
        if (idx == `LPF_IDX_MODE1)
          prdata <= {24'h00_0000, mode1_r};
        else if (idx == `LPF_IDX_SECOND_MODE_REGISTER)
          prdata <= {24'h00_0000, second_mode_register_r};
        else if (idx >= `LPF_IDX_DUTY0 && idx <= `LPF_IDX_DUTY15)
          prdata <= {24'h00_0000, duty_r[idx[3:0] - 4'd2]};
        else if (idx == `LPF_IDX_GDUTY)
          prdata <= {24'h00_0000, gduty_r};
        else if (idx == `LPF_IDX_GFREQ)
          prdata <= {24'h00_0000, gfreq_r};
        else if (idx == `LPF_IDX_CHEN)
          prdata <= {16'h0000, chen_r};
        else if (idx == `LPF_IDX_EFLO)
          prdata <= {24'h00_0000, err_ok[7:0]};
        else if (idx == `LPF_IDX_EFHI)
          prdata <= {24'h00_0000, err_ok[15:8]};
      end
    end
  end

  // ==========================================================
  // Software registers; soft reset call restores zero defaults
  // zero defaults
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode1_r <= `LPF_RST_BYTE;
      second_mode_register_r <= `LPF_RST_BYTE;
      gduty_r <= `LPF_RST_BYTE;
      gfreq_r <= `LPF_RST_BYTE;
      chen_r <= {NCH{1'b0}};
    end else if (srst_r) begin
      mode1_r <= `LPF_RST_BYTE;
      second_mode_register_r <= `LPF_RST_BYTE;
      gduty_r <= `LPF_RST_BYTE;
      gfreq_r <= `LPF_RST_BYTE;
      chen_r <= {NCH{1'b0}};
    end else if (apb_acc && pwrite) begin
      if (idx == `LPF_IDX_MODE1)
        mode1_r <= pwdata[7:0];
      if (idx == `LPF_IDX_SECOND_MODE_REGISTER)
        second_mode_register_r <= pwdata[7:0];
      if (idx == `LPF_IDX_GDUTY)
        gduty_r <= pwdata[7:0];
      if (idx == `LPF_IDX_GFREQ)
        gfreq_r <= pwdata[7:0];
      if (idx == `LPF_IDX_CHEN)
        chen_r <= pwdata[NCH-1:0];
    end
  end

  // Per-channel duty words, one storage slot each
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          duty_r[g] <= `LPF_RST_BYTE;
        else if (srst_r)
          duty_r[g] <= `LPF_RST_BYTE;
        else if (apb_acc && pwrite && idx == `LPF_IDX_DUTY0 + g)
          duty_r[g] <= pwdata[7:0];
      end

      // Fault records; a held clear bit blocks new overtemperature
      // records, which is why software must write it back to zero
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ol_r[g] <= 1'b0;
          ot_r[g] <= 1'b0;
        end else if (srst_r) begin
          ol_r[g] <= 1'b0;
          ot_r[g] <= 1'b0;
        end else begin
          if (led_on[g])
            ol_r[g] <= ol_s_r[g];
          if (ot_clr)
            ot_r[g] <= 1'b0;
          else if (otg || (otc_s_r[g] && chen_r[g]))
            ot_r[g] <= 1'b1;
        end
      end

      // Output: latch, group gate, own duty, thermal and osc gating
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          led_on[g] <= 1'b0;
        else
          led_on[g] <= chen_r[g] && !osc_off && !otg && !otc_s_r[g] &&
            grp_on && (ind_r[7:0] < duty_r[g]) && !srst_r;
      end
    end
  endgenerate

  // ==========================================================
  // Modulation counters: 40 ns quantum, 256-step channel phase,
  // group step every two channel periods, every 16 x (gfreq_r + 1) channel periods in blink mode
  // channel period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 4'h0;
      ind_r <= 9'h000;
      pre_r <= 11'h000;
      grp_r <= 8'h00;
      blink_r <= 1'b0;
    end else begin
      q_r <= qtick ? 4'h0 : q_r + 4'd1;
      if (qtick)
        ind_r <= ind_r + 9'd1;
      if (gtick)
        pre_r <= (pre_r == pre_end) ? 11'h000 : pre_r + 11'd1;
      if (gstep) begin
        grp_r <= grp_r + 8'd1;
        if (grp_r == 8'hFF)
          blink_r <= second_mode_register_r[`LPF_BLINK_BIT];
      end
    end
  end

  // ==========================================================
  // Soft reset call receiver on the two-wire link
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= PH_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ackph_r <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      srst_r <= 1'b0;
      if (start_c) begin
        ph_r <= PH_ADDR;
        bit_r <= 4'h0;
        ackph_r <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        srst_r <= (ph_r == PH_DONE);
        ph_r <= PH_IDLE;
        ackph_r <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (ph_r != PH_IDLE) begin
        if (scl_rise && !ackph_r && bit_r < 4'd8) begin
          sh_r <= {sh_r[6:0], sda_s_r[1]};
          bit_r <= bit_r + 4'd1;
        end
        if (scl_fall) begin
          if (ackph_r) begin
            // Release after the acknowledge clock
            ackph_r <= 1'b0;
            sda_oe_n <= 1'b1;
            bit_r <= 4'h0;
          end else if (bit_r == 4'd8) begin
            ackph_r <= 1'b1;
            if (ph_r == PH_DONE) begin
              sda_oe_n <= 1'b1;
            end else if (sh_r == want) begin
              sda_oe_n <= 1'b0;
              ph_r <= ph_r + 3'd1;
            end else begin
              sda_oe_n <= 1'b1;
              ph_r <= PH_IDLE;
            end
          end
        end
      end
    end
  end

endmodule // lpf_ctrl

// ===== shared/lpf_defs.vh
// Constants for the LED modulation, fault and reset controller
`ifndef LPF_DEFS_VH
`define LPF_DEFS_VH

// ==========================================================
// Register indexes (byte address is four times the index)
`define LPF_IDX_MODE1 6'h00
`define LPF_IDX_SECOND_MODE_REGISTER 6'h01
`define LPF_IDX_DUTY0 6'h02
`define LPF_IDX_DUTY15 6'h11
`define LPF_IDX_GDUTY 6'h12
`define LPF_IDX_GFREQ 6'h13
`define LPF_IDX_CHEN 6'h14
`define LPF_IDX_EFLO 6'h1D
`define LPF_IDX_EFHI 6'h1E

// ==========================================================
// Field positions
`define LPF_OSC_OFF_BIT 4
`define LPF_OT_CLR_BIT 7
`define LPF_BLINK_BIT 5

// ==========================================================
// Reset values (everything clears to zero)
`define LPF_RST_BYTE 8'h00
`define LPF_RST_WORD 32'h0000_0000

// ==========================================================
// Timing: clock rate and the 40 ns modulation quantum
`define LPF_CLK_MHZ 250
`define LPF_QUANTUM_NS 40
`define LPF_QUANTUM_CYC ((`LPF_QUANTUM_NS * `LPF_CLK_MHZ + 999) / 1000)

// ==========================================================
// Soft reset call bytes on the two-wire link
`define LPF_SR_ADDR 8'hD6
`define LPF_SR_BYTE1 8'hA5
`define LPF_SR_BYTE2 8'h5A

`endif

// ===== bench/lpf_assertions.sv
// Port checks for the LED modulation, fault and reset controller
`timescale 1ns/1ns
`include "lpf_defs.vh"
module lpf_assertions #(
  parameter NCH = 16
) (
  // APB side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Link side
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_n,
  // Faults and outputs
  input wire [NCH-1:0] open_load_i,
  input wire [NCH-1:0] ot_chan_i,
  input wire ot_global_i,
  input wire [NCH-1:0] led_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  rst_clear_a: assert property ($rose(presetn) |->
    led_on == 0 && sda_oe_n && !pready) else $error("not idle after reset");
  glob_ot_off_a: assert property (ot_global_i [*6] |-> led_on == 0)
    else $error("channel on in global overtemperature");
  // Sync delay of the comparators to led_on is exactly three cycles
  chan_ot_off_a: assert property ((led_on & ot_chan_i &
    $past(ot_chan_i, 3) & $past(ot_chan_i, 6)) == 0)
    else $error("channel on in its own overtemperature");
  ack_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3])
    else $error("acknowledge too short");
  idle_release_a: assert property (scl_i [*8] |-> sda_oe_n)
    else $error("data line held while link idle");
  flag_width_a: assert property (pready && !pwrite &&
    paddr == {`LPF_IDX_EFHI, 2'b00} |-> prdata[31:8] == 0)
    else $error("flag register wider than a byte");
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access not one wait state");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error response without ready");
  idle_data_a: assert property (!pready |-> prdata == 0)
    else $error("read data outside access");
  sda_low_a: assert property (!sda_oe_n |-> !sda_o)
    else $error("open drain drives high");
  // Main scenarios reached
  cover property ($fell(sda_oe_n));
  cover property (pslverr);
  cover property (ot_global_i && led_on == 0);
endmodule // lpf_assertions

// ===== bench/lpf_wire_master.sv
// Two-wire bus master model issuing soft reset calls
`timescale 1ns/1ns
module lpf_wire_master (
  // Clock
  input wire pclk,
  // Link lines, data released when sda_drv is 1
  output logic scl,
  output logic sda_drv,
  input wire sda_in
);
  // ==========================================================
  // Idle lines rest high, clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One 32 ns link clock: data set mid-low, sampled at end of high
  task clk_bit(input logic v, output logic s);
    repeat (2) @(posedge pclk);
    sda_drv <= v;
    repeat (2) @(posedge pclk);
    scl <= 1'b1;
    repeat (4) @(posedge pclk);
    s = sda_in;
    scl <= 1'b0;
  endtask
  task start;
    repeat (4) @(posedge pclk);
    sda_drv <= 1'b0;
    repeat (4) @(posedge pclk);
    scl <= 1'b0;
  endtask
  task send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, ack);
    // Stretch low so the device lets go of its ack first
    repeat (8) @(posedge pclk);
  endtask
  task stop;
    repeat (2) @(posedge pclk);
    sda_drv <= 1'b0;
    repeat (2) @(posedge pclk);
    scl <= 1'b1;
    repeat (4) @(posedge pclk);
    sda_drv <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
endmodule // lpf_wire_master

// ===== bench/lpf_ctrl_bench.sv
// Self-checking bench for the LED modulation and reset controller
`timescale 1ns/1ns
`include "lpf_defs.vh"
module lpf_ctrl_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ot_global_i = 1'b0, er_v, ack;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd_v;
  logic [15:0] open_load_i = 16'h0000, ot_chan_i = 16'h0000;
  logic [7:0] duty [16];
  wire [31:0] prdata;
  wire pready, pslverr, scl, sda_drv, sda_o, sda_oe_n;
  wire [15:0] led_on;
  // Pull-up wins unless a party pulls low
  wire sda_w = sda_drv & (sda_oe_n | sda_o);
  int err_count = 0, total_checks = 0, cyc = 0, seed = 77808, i, c;
  lpf_ctrl #(.NCH(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl),
    .sda_i(sda_w), .sda_o, .sda_oe_n, .open_load_i, .ot_chan_i,
    .ot_global_i, .led_on);
  lpf_wire_master m (.pclk, .scl, .sda_drv, .sda_in(sda_w));
  // ==========================================================
  // Clock and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done;
    end
  end
  // Expected values
  function logic [7:0] ad(input int x);
    return {6'(x), 2'b00};
  endfunction
  function logic unmapped(input int x);
    return (x > 'h14 && x < 'h1D) || x > 'h1E;
  endfunction
  task test_done;
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // APB transfer, held until ready is sampled, one idle cycle after
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) err_count++;
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rchk(input int x, input logic [31:0] e);
    apb(1'b0, ad(x), 32'h0000_0000);
    chk(rd_v, e);
  endtask
  task sb(input logic [7:0] b, input logic e);
    m.send(b, ack);
    chk(ack, e);
  endtask
  // High cycles of one channel over one channel period
  task count_on(input int k);
    c = 0;
    repeat (256 * `LPF_QUANTUM_CYC) begin
      @(posedge pclk);
      c += (led_on[k] === 1'b1);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 32; i++) begin
      apb(1'b0, ad(i), 32'h0000_0000);
      chk(rd_v, 32'h0000_0000);
      chk(er_v, unmapped(i));
    end
    // Random duties with minimum and full corners
    for (i = 0; i < 16; i++) begin
      duty[i] = (i == 0) ? 8'h01 : (i == 2) ? 8'hFF : 8'($random(seed));
      apb(1'b1, ad(`LPF_IDX_DUTY0 + i), {24'h00_0000, duty[i]});
      rchk(`LPF_IDX_DUTY0 + i, {24'h00_0000, duty[i]});
    end
    apb(1'b1, ad(`LPF_IDX_GDUTY), 32'h0000_00FF);
    apb(1'b1, ad(`LPF_IDX_CHEN), 32'h0000_FFFF);
    for (i = 0; i < 6; i += 5) begin
      count_on(i);
      chk(c, duty[i] * `LPF_QUANTUM_CYC);
    end
    apb(1'b1, ad(`LPF_IDX_GDUTY), 32'h0000_0000);
    count_on(2);
    chk(c, 0);
    apb(1'b1, ad(`LPF_IDX_GDUTY), 32'h0000_00FF);
    apb(1'b1, ad(`LPF_IDX_MODE1), 32'h0000_0010);
    count_on(2);
    chk(c, 0);
    apb(1'b1, ad(`LPF_IDX_MODE1), 32'h0000_0000);
    rchk(`LPF_IDX_EFHI, 32'h0000_00FF);
    // Faults: open load, channel and global overtemperature
    open_load_i[2] <= 1'b1;
    repeat (20) @(posedge pclk);
    rchk(`LPF_IDX_EFLO, 32'h0000_00FB);
    open_load_i[2] <= 1'b0;
    ot_chan_i[9] <= 1'b1;
    repeat (20) @(posedge pclk);
    rchk(`LPF_IDX_EFLO, 32'h0000_00FF);
    rchk(`LPF_IDX_EFHI, 32'h0000_00FD);
    ot_chan_i[9] <= 1'b0;
    // Sensor release needs three clocks through the sync flops
    repeat (4) @(posedge pclk);
    count_on(9);
    chk(c, duty[9] * `LPF_QUANTUM_CYC);
    rchk(`LPF_IDX_EFHI, 32'h0000_00FD);
    ot_global_i <= 1'b1;
    repeat (20) @(posedge pclk);
    rchk(`LPF_IDX_EFLO, 32'h0000_0000);
    ot_global_i <= 1'b0;
    repeat (20) @(posedge pclk);
    rchk(`LPF_IDX_EFHI, 32'h0000_0000);
    apb(1'b1, ad(`LPF_IDX_SECOND_MODE_REGISTER), 32'h0000_0080);
    apb(1'b1, ad(`LPF_IDX_SECOND_MODE_REGISTER), 32'h0000_0000);
    rchk(`LPF_IDX_EFHI, 32'h0000_00FF);
    // Soft reset calls: refused forms, then a complete one
    m.start;
    sb(8'hD7, 1'b1);
    m.stop;
    m.start;
    sb(`LPF_SR_ADDR, 1'b0);
    sb(8'hA4, 1'b1);
    m.stop;
    rchk(`LPF_IDX_GDUTY, 32'h0000_00FF);
    m.start;
    sb(`LPF_SR_ADDR, 1'b0);
    sb(`LPF_SR_BYTE1, 1'b0);
    sb(`LPF_SR_BYTE2, 1'b0);
    sb(8'($random(seed)), 1'b1);
    m.stop;
    rchk(`LPF_IDX_GDUTY, 32'h0000_0000);
    rchk(`LPF_IDX_CHEN, 32'h0000_0000);
    test_done;
  end
endmodule // lpf_ctrl_bench
bind lpf_ctrl lpf_assertions #(.NCH(NCH)) chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i,
  .sda_i, .sda_o, .sda_oe_n, .open_load_i, .ot_chan_i, .ot_global_i,
  .led_on);
